// File: rtl/intc_pkg.sv
// constants of the interrupt priority and status unit
// assumes an apb master on pclk and a cpu core at the exception port
package intc_pkg;
	localparam int NUM_SRC = 16;
	localparam int NUM_TRAP = 4;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_WAKE_PRI = 12'h008;
	localparam logic [11:0] OFF_FLAG = 12'h00c;
	localparam logic [11:0] OFF_ENABLE = 12'h010;
	localparam logic [11:0] OFF_PRI_BASE = 12'h020;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h040;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h044;
	localparam logic [11:0] OFF_TIMED_DISABLE_OP_CNT = 12'h048;
	localparam int CTRL_NEST_DIS_BIT = 15;
	localparam int STAT_UNACK_BIT = 15;
	localparam int STAT_VECTOR_HOLD_SELECT_BIT = 13;
	localparam int STAT_LEVEL_LSB = 8;
	localparam int STAT_VEC_LSB = 0;
	localparam int WAKE_PRI_LSB = 4;
	localparam logic [2:0] PRI_RESET = 3'h4;
	localparam logic [2:0] PRI_OFF = 3'h0;
	localparam logic [3:0] LEVEL_MASK_ALL = 4'h7;
	localparam logic [2:0] PRI_TIMED_DISABLE_OP_IMMUNE = 3'h7;
	localparam logic [6:0] VEC_TRAP_BASE = 7'h00;
	localparam logic [6:0] VEC_SRC_BASE = 7'h08;
	localparam logic [6:0] VEC_WAKE = 7'h3f;
	localparam logic [3:0] LEVEL_TRAP_BASE = 4'h8;
	localparam int IRQ_TAKEN_BIT = 0;
	localparam int IRQ_TRAP_BIT = 1;
	localparam int IRQ_TIMED_DISABLE_OP_END_BIT = 2;
endpackage

// File: rtl/interrupt_priority_status_unit.sv
// interrupt priority and status unit: per-source priority, arbitration,
// status register, nesting disable and timed disable
// assumes source flags arrive as same-clock pulses and the cpu acks in pclk domain
// Operation
// - priority 111 is level 7 down to 001 level 1; 000 disables
// - a zero-priority source never raises a request
// - status bit 15 set while a request waits behind cpu level
// - vector hold one: vector field shows highest pending interrupt
// - vector hold zero: vector field shows last acknowledged interrupt
// - bits 11..8 report the new cpu priority level 0..11
// - bits 6..0 report vector, code 0 meaning vector 8
// - reset loads every source priority field with level 4
// - nesting disable bit 15 stops preemption of a serviced interrupt
// - a source requests only when its enable bit is set
// - flags are not cleared on entry; an uncleared flag retakes service
// - return restores saved pc, status low byte and previous level
// - trap flags stay set until software clears them
// - cpu level 7 masks all user interrupts; a level load ors into the level, so only a return unmasks
// - traps at levels 8..11 are masked by a cpu level at or above their own and by nesting disable
// - timed disable blocks priorities 1..6 for a set interval, not 7
// - wake-up source has its own priority field at bits 6..4
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_status_unit
	import intc_pkg::*;
#(
	parameter int N_SRC = NUM_SRC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [N_SRC-1:0] src_event,
	input wire logic wake_event,
	input wire logic [NUM_TRAP-1:0] trap_event,
	input wire logic [3:0] cpu_level,
	input wire logic cpu_level_load,
	input wire logic [3:0] cpu_level_wdata,
	input wire logic cpu_in_service,
	input wire logic irq_ack,
	input wire logic [15:0] ack_pc,
	input wire logic [7:0] ack_status_low,
	input wire logic ret_op,
	input wire logic timed_disable_op_op,
	output logic irq_req,
	output logic [6:0] irq_vector,
	output logic [3:0] irq_new_level,
	output logic [15:0] ret_pc,
	output logic [7:0] ret_status_low,
	output logic [3:0] ret_level,
	output logic [3:0] cpu_level_out,
	output logic irq
);
	// widths above 31 would collide with the wake bit at 31 of the flag word
	if (N_SRC < 1 || N_SRC > 31) begin : g_bad_n_src
		$error("n_src out of range");
	end
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [N_SRC-1:0] flag_reg;
	logic [N_SRC-1:0] enable_reg;
	logic [2:0] pri_reg [N_SRC];
	logic [2:0] wake_pri_reg;
	logic wake_flag_reg;
	logic wake_en_reg;
	logic [NUM_TRAP-1:0] trap_flag_reg;
	logic nest_dis_reg;
	logic vector_hold_select_reg;
	logic [6:0] last_vec_reg;
	logic [3:0] last_level_reg;
	logic [3:0] level_reg;
	logic [15:0] timed_disable_op_cnt_reg;
	logic [15:0] timed_disable_op_load_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic [15:0] stk_pc_reg;
	logic [7:0] stk_sr_reg;
	logic [3:0] stk_level_reg;
	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire sel_ctrl = paddr == OFF_CTRL;
	wire sel_status = paddr == OFF_STATUS;
	wire sel_wake = paddr == OFF_WAKE_PRI;
	wire sel_flag = paddr == OFF_FLAG;
	wire sel_enable = paddr == OFF_ENABLE;
	wire sel_pri = paddr >= OFF_PRI_BASE && paddr < OFF_PRI_BASE + 12'(4 * ((N_SRC + 3) / 4));
	wire [2:0] pri_grp = 3'(paddr[11:2] - OFF_PRI_BASE[11:2]);
	wire sel_istat = paddr == OFF_IRQ_STAT;
	wire sel_imask = paddr == OFF_IRQ_MASK;
	wire sel_timed_disable_op = paddr == OFF_TIMED_DISABLE_OP_CNT;
	wire mapped = sel_ctrl | sel_status | sel_wake | sel_flag | sel_enable | sel_pri
		| sel_istat | sel_imask | sel_timed_disable_op;
	wire bad = !mapped || paddr[1:0] != 2'h0;
	wire wr_ok = wr_en && !bad;
	// zero wait states; errors only flag the transfer, they never stall it
	assign pready = 1'b1;
	assign pslverr = psel && penable && bad;
	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	// every comparison uses the level held here, never the core's copy
	wire [3:0] cur_level = level_reg;
	wire timed_disable_op_active = timed_disable_op_cnt_reg != 16'h0000;
	logic [N_SRC-1:0] src_live;
	logic [N_SRC-1:0] src_above;
	genvar g;
	generate
		for (g = 0; g < N_SRC; g++) begin : g_src
			// zero priority or clear enable keeps the source silent
			assign src_live[g] = flag_reg[g] && enable_reg[g] && pri_reg[g] != PRI_OFF;
			// timed disable spares priority 7 only
			assign src_above[g] = src_live[g] && {1'b0, pri_reg[g]} > cur_level
				&& (!timed_disable_op_active || pri_reg[g] == PRI_TIMED_DISABLE_OP_IMMUNE);
		end
	endgenerate
	wire wake_live = wake_flag_reg && wake_en_reg && wake_pri_reg != PRI_OFF;
	wire wake_above = wake_live && {1'b0, wake_pri_reg} > cur_level
		&& (!timed_disable_op_active || wake_pri_reg == PRI_TIMED_DISABLE_OP_IMMUNE);
	logic [2:0] best_pri;
	logic [6:0] best_vec;
	logic best_any;
	logic [2:0] pend_pri;
	logic [6:0] pend_vec;
	logic pend_any;
	logic blocked_any;
	// lower vector wins a tie: scan downward and replace on >=
	always_comb begin
		best_pri = 3'h0;
		best_vec = 7'h00;
		best_any = 1'b0;
		pend_pri = 3'h0;
		pend_vec = 7'h00;
		pend_any = 1'b0;
		blocked_any = 1'b0;
		if (wake_above) begin
			best_any = 1'b1;
			best_pri = wake_pri_reg;
			best_vec = VEC_WAKE;
		end
		if (wake_live) begin
			pend_any = 1'b1;
			pend_pri = wake_pri_reg;
			pend_vec = VEC_WAKE;
			blocked_any = !wake_above;
		end
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (src_above[i] && (!best_any || pri_reg[i] >= best_pri)) begin
				best_any = 1'b1;
				best_pri = pri_reg[i];
				best_vec = VEC_SRC_BASE + 7'(i);
			end
			if (src_live[i] && (!pend_any || pri_reg[i] >= pend_pri)) begin
				pend_any = 1'b1;
				pend_pri = pri_reg[i];
				pend_vec = VEC_SRC_BASE + 7'(i);
			end
			if (src_live[i] && !src_above[i]) begin
				blocked_any = 1'b1;
			end
		end
	end
	// traps: masked by a level at or above their own or by nesting disable, lowest index is highest level
	logic trap_any;
	logic [1:0] trap_idx;
	always_comb begin
		trap_any = 1'b0;
		trap_idx = 2'h0;
		for (int t = NUM_TRAP - 1; t >= 0; t--) begin
			if (trap_flag_reg[t]) begin
				trap_any = 1'b1;
				trap_idx = 2'(t);
			end
		end
	end
	wire [3:0] trap_level = LEVEL_TRAP_BASE + 4'(NUM_TRAP - 1) - 4'(trap_idx);
	// nesting disable holds off every request while a handler runs
	wire nest_block = nest_dis_reg && cpu_in_service;
	// traps still need a level above the one in service, so they rank among themselves
	wire trap_ok = trap_any && (trap_level > cur_level) && !nest_block;
	wire user_ok = best_any && !nest_block;
	assign irq_req = trap_ok || user_ok;
	assign irq_vector = trap_ok ? VEC_TRAP_BASE + 7'(trap_idx) : best_vec;
	assign irq_new_level = trap_ok ? trap_level : {1'b0, best_pri};
	// ----------------------------------------------------------------
	// status register read view
	// ----------------------------------------------------------------
	// blocked by the cpu level or by the timed disable alike
	wire unack = blocked_any;
	// the vector field is offset by eight: code zero means vector eight
	wire [6:0] shown_vec = vector_hold_select_reg ? pend_vec - VEC_SRC_BASE : last_vec_reg;
	wire [15:0] status_view = (16'(unack) << STAT_UNACK_BIT)
		| (16'(vector_hold_select_reg) << STAT_VECTOR_HOLD_SELECT_BIT)
		| (16'(last_level_reg) << STAT_LEVEL_LSB)
		| (16'(shown_vec) << STAT_VEC_LSB);
	logic [31:0] pri_word;
	always_comb begin
		pri_word = 32'h0000_0000;
		for (int k = 0; k < 4; k++) begin
			if (int'(pri_grp) * 4 + k < N_SRC) begin
				pri_word[k*4 +: 3] = pri_reg[int'(pri_grp) * 4 + k];
			end
		end
	end
	// ----------------------------------------------------------------
	// read words
	// ----------------------------------------------------------------
	wire [31:0] ctrl_word = 32'((16'(nest_dis_reg) << CTRL_NEST_DIS_BIT) | 16'(trap_flag_reg));
	wire [31:0] status_word = 32'(status_view);
	wire [31:0] wake_word = 32'(16'(wake_pri_reg) << WAKE_PRI_LSB);
	wire [31:0] flag_word = 32'({wake_flag_reg, 31'(flag_reg)});
	wire [31:0] enable_word = 32'({wake_en_reg, 31'(enable_reg)});
	wire [31:0] timed_disable_op_word = {timed_disable_op_load_reg, timed_disable_op_cnt_reg};
	// an unmapped or unaligned address reads as zero
	wire [31:0] rd_mux = bad ? 32'h0000_0000
		: sel_ctrl ? ctrl_word
		: sel_status ? status_word
		: sel_wake ? wake_word
		: sel_flag ? flag_word
		: sel_enable ? enable_word
		: sel_pri ? pri_word
		: sel_istat ? 32'(irq_stat_reg)
		: sel_imask ? 32'(irq_mask_reg)
		: sel_timed_disable_op ? timed_disable_op_word
		: 32'h0000_0000;
	// read data is taken in the setup cycle and stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end
	wire unused_rd = rd_en;
	// ----------------------------------------------------------------
	// flags: hardware set beats software clear
	// ----------------------------------------------------------------
	logic [N_SRC-1:0] flag_next;
	wire flag_hit = wr_ok && sel_flag && pstrb != 4'h0;
	wire [N_SRC-1:0] flag_wr = flag_hit ? pwdata[N_SRC-1:0] : flag_reg;
	wire wake_flag_wr = flag_hit ? pwdata[31] : wake_flag_reg;
	// trap flags clear only through a software write of zero
	wire [NUM_TRAP-1:0] trap_wr = (wr_ok && sel_ctrl) ? pwdata[NUM_TRAP-1:0] & trap_flag_reg
		: trap_flag_reg;
	// flags stay until software clears them; ack does not touch them
	assign flag_next = flag_wr | src_event;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= '0;
			wake_flag_reg <= 1'b0;
			trap_flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
			wake_flag_reg <= wake_event | wake_flag_wr;
			trap_flag_reg <= trap_event | trap_wr;
		end
	end
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= '0;
			wake_en_reg <= 1'b0;
			nest_dis_reg <= 1'b0;
			vector_hold_select_reg <= 1'b0;
			wake_pri_reg <= PRI_RESET;
			irq_mask_reg <= '0;
			timed_disable_op_load_reg <= 16'h0000;
		end else if (wr_ok) begin
			if (sel_enable) begin
				enable_reg <= pwdata[N_SRC-1:0];
				wake_en_reg <= pwdata[31];
			end
			if (sel_ctrl) begin
				nest_dis_reg <= pwdata[CTRL_NEST_DIS_BIT];
			end
			if (sel_status) begin
				vector_hold_select_reg <= pwdata[STAT_VECTOR_HOLD_SELECT_BIT];
			end
			if (sel_wake) begin
				wake_pri_reg <= pwdata[WAKE_PRI_LSB +: 3];
			end
			if (sel_imask) begin
				irq_mask_reg <= pwdata[2:0];
			end
			if (sel_timed_disable_op) begin
				timed_disable_op_load_reg <= pwdata[31:16];
			end
		end
	end
	// four priority fields to a word, one nibble each
	generate
		for (g = 0; g < N_SRC; g++) begin : g_pri
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pri_reg[g] <= PRI_RESET;
				end else if (wr_ok && sel_pri && int'(pri_grp) == g / 4) begin
					pri_reg[g] <= pwdata[(g % 4) * 4 +: 3];
				end
			end
		end
	endgenerate
	// ----------------------------------------------------------------
	// cpu level, acknowledge capture, return stack, timed disable
	// ----------------------------------------------------------------
	// acknowledge wins over return and level load in the same cycle
	// one level of return stack: deeper nesting needs software to save state
	wire taking = irq_ack && irq_req;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= 4'h0;
			last_vec_reg <= 7'h00;
			last_level_reg <= 4'h0;
			stk_pc_reg <= 16'h0000;
			stk_sr_reg <= 8'h00;
			stk_level_reg <= 4'h0;
		end else if (taking) begin
			level_reg <= irq_new_level;
			last_vec_reg <= irq_vector - VEC_SRC_BASE;
			last_level_reg <= irq_new_level;
			stk_pc_reg <= ack_pc;
			stk_sr_reg <= ack_status_low;
			stk_level_reg <= level_reg;
		end else if (ret_op) begin
			level_reg <= stk_level_reg;
		end else if (cpu_level_load) begin
			// software raising to 7 masks users; the load ors into the level, so only a return lowers it
			level_reg <= cpu_level_wdata | cpu_level;
		end
	end
	assign ret_pc = stk_pc_reg;
	assign ret_status_low = stk_sr_reg;
	assign ret_level = stk_level_reg;
	assign cpu_level_out = level_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timed_disable_op_cnt_reg <= 16'h0000;
		end else if (timed_disable_op_op) begin
			timed_disable_op_cnt_reg <= timed_disable_op_load_reg;
		end else if (wr_ok && sel_timed_disable_op) begin
			timed_disable_op_cnt_reg <= pwdata[15:0];
		end else if (timed_disable_op_active) begin
			timed_disable_op_cnt_reg <= timed_disable_op_cnt_reg - 16'h0001;
		end
	end
	// ----------------------------------------------------------------
	// interrupt status, write one to clear, set wins
	// ----------------------------------------------------------------
	// end of interval is flagged on the last count unless a reload lands
	wire timed_disable_op_end = timed_disable_op_cnt_reg == 16'h0001 && !timed_disable_op_op;
	wire [2:0] ev = (3'(taking) << IRQ_TAKEN_BIT) | (3'(|trap_event) << IRQ_TRAP_BIT)
		| (3'(timed_disable_op_end) << IRQ_TIMED_DISABLE_OP_END_BIT);
	wire [2:0] w1c = (wr_ok && sel_istat) ? pwdata[2:0] : 3'h0;
	// an event in the cycle of its clear keeps the bit set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule // interrupt_priority_status_unit
`default_nettype wire

// File: testbench/cpu_core_model.sv
// cpu core exception entry and return, seen from the interrupt unit
// assumes commands from the bench one cycle wide on pclk
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_req,
	input wire logic [3:0] cpu_level_out,
	input wire logic take_cmd,
	input wire logic ret_cmd,
	input wire logic [3:0] ack_delay,
	output logic irq_ack,
	output logic [15:0] ack_pc,
	output logic [7:0] ack_status_low,
	output logic ret_op,
	output logic cpu_in_service,
	output logic [3:0] cpu_level
);
	logic armed_reg;
	logic [3:0] wait_reg;
	// flags and trap bits are left to software, never cleared here
	assign cpu_level = cpu_level_out;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_reg <= 1'b0;
			wait_reg <= 4'h0;
			irq_ack <= 1'b0;
			ack_pc <= 16'h0100;
			ack_status_low <= 8'h00;
			ret_op <= 1'b0;
			cpu_in_service <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			ret_op <= ret_cmd;
			if (ret_cmd)
				cpu_in_service <= 1'b0;
			if (take_cmd) begin
				armed_reg <= 1'b1;
				wait_reg <= ack_delay;
			end else if (armed_reg && irq_req && !irq_ack) begin
				if (wait_reg != 4'h0)
					wait_reg <= wait_reg - 4'h1;
				else begin
					irq_ack <= 1'b1;
					armed_reg <= 1'b0;
					cpu_in_service <= 1'b1;
					ack_pc <= ack_pc + 16'h0102;
					ack_status_low <= ~ack_status_low;
				end
			end
		end
	end
endmodule // cpu_core_model
`default_nettype wire

// File: testbench/intc_props.sv
// assertions on the ports of the interrupt priority and status unit
// assumes a single pclk domain with asynchronous active-low presetn
`timescale 1ns/10ps
`default_nettype none
module intc_props
	import intc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_TRAP-1:0] trap_event,
	input wire logic [3:0] cpu_level,
	input wire logic cpu_level_load,
	input wire logic [3:0] cpu_level_wdata,
	input wire logic cpu_in_service,
	input wire logic irq_ack,
	input wire logic [15:0] ack_pc,
	input wire logic ret_op,
	input wire logic irq_req,
	input wire logic [6:0] irq_vector,
	input wire logic [3:0] irq_new_level,
	input wire logic [15:0] ret_pc,
	input wire logic [3:0] ret_level,
	input wire logic [3:0] cpu_level_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error response outside access phase");
	a_ack_level: assert property (irq_ack && irq_req |=> cpu_level_out == $past(irq_new_level))
		else $error("level not taken from acknowledged request");
	a_ack_stack: assert property (irq_ack && irq_req |=> ret_pc == $past(ack_pc))
		else $error("saved pc not stacked on acknowledge");
	a_ret_level: assert property (ret_op && !irq_ack |=> cpu_level_out == $past(ret_level))
		else $error("return did not restore level");
	a_or_level: assert property (cpu_level_load && !irq_ack && !ret_op
		|=> cpu_level_out == $past(cpu_level_wdata | cpu_level))
		else $error("level load not ored");
	a_req_above: assert property (irq_req |-> irq_new_level > cpu_level_out)
		else $error("request not above cpu level");
	a_mask_user: assert property (irq_req && cpu_level_out >= LEVEL_MASK_ALL
		|-> irq_new_level >= LEVEL_TRAP_BASE)
		else $error("user request at level seven");
	a_trap_pass: assert property (trap_event[0] && !irq_ack && !cpu_level_load
		&& !cpu_in_service && cpu_level_out < 4'hb |=> irq_req)
		else $error("trap masked by cpu level");
	a_vec_user: assert property (irq_req && irq_new_level < 4'h8 |-> irq_vector >= 7'h08)
		else $error("user vector below eight");
	cover property (irq_ack && irq_req);
	cover property (ret_op);
	cover property (irq_req && irq_new_level > 4'h7);
endmodule // intc_props
bind interrupt_priority_status_unit intc_props i_intc_props (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .trap_event, .cpu_level, .cpu_level_load, .cpu_level_wdata,
	.cpu_in_service, .irq_ack, .ack_pc, .ret_op, .irq_req, .irq_vector, .irq_new_level,
	.ret_pc, .ret_level, .cpu_level_out);
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the interrupt priority and status unit
// assumes the cpu core model at the exception port and the bound checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
	import intc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, take = 0, rtn = 0;
	logic lvl_load = 0, timed_disable_op = 0, pready, pslverr, ev, irq_req, irq, irq_ack, ret_op, in_svc;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv;
	logic [15:0] src_event = '0, ack_pc, ret_pc;
	logic [3:0] trap_event = '0, lvl_wdata = '0, dly = '0, cpu_level, cpu_level_out, new_lvl;
	logic [3:0] ret_level;
	logic wake = 0;
	logic [6:0] vec;
	logic [7:0] asl, rsl;
	int err_count = 0, total_checks = 0, cyc = 0;
	always #20 pclk = ~pclk;
	interrupt_priority_status_unit i_interrupt_priority_status_unit (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.src_event, .wake_event(wake), .trap_event, .cpu_level, .cpu_level_load(lvl_load),
		.cpu_level_wdata(lvl_wdata), .cpu_in_service(in_svc), .irq_ack, .ack_pc,
		.ack_status_low(asl), .ret_op, .timed_disable_op_op(timed_disable_op), .irq_req, .irq_vector(vec),
		.irq_new_level(new_lvl), .ret_pc, .ret_status_low(rsl), .ret_level, .cpu_level_out, .irq);
	cpu_core_model i_cpu_core_model (.pclk, .presetn, .irq_req, .cpu_level_out, .take_cmd(take),
		.ret_cmd(rtn), .ack_delay(dly), .irq_ack, .ack_pc, .ack_status_low(asl), .ret_op,
		.cpu_in_service(in_svc), .cpu_level);
	// ----------------------------------------
	// bus and core tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", e, rv)
	endtask
	task automatic pulse(input logic [15:0] s, input logic [3:0] t, input logic d);
		@(posedge pclk);
		src_event <= s;
		trap_event <= t;
		timed_disable_op <= d;
		@(posedge pclk);
		src_event <= '0;
		trap_event <= '0;
		timed_disable_op <= 1'b0;
	endtask
	task automatic chk_req(input logic e, input logic [3:0] l);
		@(negedge pclk);
		`CHK("irq_req", e, irq_req)
		if (e)
			`CHK("irq_new_level", l, new_lvl)
	endtask
	task automatic chk_irq(input logic e);
		@(negedge pclk);
		`CHK("irq", e, irq)
	endtask
	task automatic take_irq(input logic [3:0] d);
		@(posedge pclk);
		dly <= d;
		take <= 1'b1;
		@(posedge pclk);
		take <= 1'b0;
		while (irq_ack !== 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask
	task automatic ret_irq;
		@(posedge pclk);
		rtn <= 1'b1;
		@(posedge pclk);
		rtn <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			report_and_stop;
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk_rd(OFF_PRI_BASE, 32'h00004444);
		chk_rd(OFF_WAKE_PRI, 32'h00000040);
		chk_rd(OFF_STATUS, 32'h00000000);
		apb(1'b0, 12'h0fc, 32'h0);
		`CHK("pslverr", 1'b1, ev)
		pulse(16'h0001, 4'h0, 1'b0);
		chk_req(1'b0, 4'h0);
		wr(OFF_ENABLE, 32'h0000000f);
		chk_req(1'b1, 4'h4);
		wr(OFF_PRI_BASE, 32'h00004440);
		chk_req(1'b0, 4'h0);
		wr(OFF_PRI_BASE, 32'h00004444);
		@(posedge pclk);
		lvl_load <= 1'b1;
		lvl_wdata <= 4'h7;
		@(posedge pclk);
		lvl_load <= 1'b0;
		chk_req(1'b0, 4'h0);
		chk_rd(OFF_STATUS, 32'h00008000);
		pulse(16'h0000, 4'h1, 1'b0);
		chk_req(1'b1, 4'hb);
		`CHK("irq_vector", 7'h00, vec)
		chk_rd(OFF_CTRL, 32'h00000001);
		wr(OFF_CTRL, 32'h0);
		chk_req(1'b0, 4'h0);
		ret_irq;
		chk_req(1'b1, 4'h4);
		wr(OFF_PRI_BASE, 32'h00004654);
		pulse(16'h000e, 4'h0, 1'b0);
		wr(OFF_STATUS, 32'h00002000);
		chk_rd(OFF_STATUS, 32'h00002002);
		wr(OFF_PRI_BASE, 32'h00004554);
		chk_req(1'b1, 4'h5);
		`CHK("irq_vector", 7'h09, vec)
		take_irq(4'h2);
		@(negedge pclk);
		`CHK("ret_pc", 16'h0202, ret_pc)
		`CHK("ret_status_low", 8'hff, rsl)
		`CHK("ret_level", 4'h0, ret_level)
		wr(OFF_PRI_BASE, 32'h00004654);
		wr(OFF_STATUS, 32'h0);
		chk_rd(OFF_STATUS, 32'h00008501);
		wr(OFF_STATUS, 32'h00002000);
		chk_rd(OFF_STATUS, 32'h0000a502);
		chk_rd(OFF_FLAG, 32'h0000000f);
		wr(OFF_CTRL, 32'h00008000);
		chk_req(1'b0, 4'h0);
		wr(OFF_CTRL, 32'h0);
		chk_req(1'b1, 4'h6);
		ret_irq;
		chk_req(1'b1, 4'h6);
		`CHK("cpu_level_out", 4'h0, cpu_level_out)
		chk_rd(OFF_IRQ_STAT, 32'h00000003);
		chk_irq(1'b0);
		wr(OFF_IRQ_MASK, 32'h1);
		chk_irq(1'b1);
		wr(OFF_IRQ_STAT, 32'h1);
		chk_irq(1'b0);
		chk_rd(OFF_IRQ_STAT, 32'h00000002);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_FLAG, 32'h0);
		wr(OFF_PRI_BASE, 32'h00007006);
		wr(OFF_TIMED_DISABLE_OP_CNT, 32'h00200000);
		pulse(16'h0001, 4'h0, 1'b1);
		chk_req(1'b0, 4'h0);
		pulse(16'h0008, 4'h0, 1'b0);
		chk_req(1'b1, 4'h7);
		wr(OFF_FLAG, 32'h1);
		chk_req(1'b0, 4'h0);
		repeat (40) @(posedge pclk);
		chk_req(1'b1, 4'h6);
		chk_rd(OFF_IRQ_STAT, 32'h00000004);
		wr(OFF_IRQ_MASK, 32'h4);
		chk_irq(1'b1);
		wr(OFF_FLAG, 32'h0);
		wr(OFF_WAKE_PRI, 32'h0);
		wr(OFF_ENABLE, 32'h8000000f);
		@(posedge pclk);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		chk_req(1'b0, 4'h0);
		wr(OFF_WAKE_PRI, 32'h00000050);
		chk_req(1'b1, 4'h5);
		`CHK("irq_vector", 7'h3f, vec)
		chk_rd(OFF_STATUS, 32'h00002537);
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
